// File: rtl/atx_ctrl.sv
// atx power/reset switch emulation with host watchdog, ahb-lite slave
`timescale 1ns/10ps
`include "atx_defs.svh"
module atx_ctrl
  import atx_pkg::*;
#(
  parameter int TICK_CYC = `ATX_TICK_CYC
) (
  input wire logic i_sys_clk, // 50 mhz system clock
  input wire logic i_rst, // sync reset, active high
  input wire logic i_hsel, // ahb slave select
  input wire logic [31:0] i_haddr, // ahb address
  input wire logic [1:0] i_htrans, // ahb transfer type
  input wire logic i_hwrite, // ahb write
  input wire logic [2:0] i_hsize, // ahb size, word only
  input wire logic [31:0] i_hwdata, // ahb write data
  input wire logic i_hready, // ahb bus ready
  output logic o_hreadyout, // ahb slave ready
  output logic [31:0] o_hrdata, // ahb read data
  output logic o_hresp, // ahb response, always okay
  input wire logic i_key_confirm, // confirm key pressed, pin
  input wire logic i_key_cancel, // cancel key pressed, pin
  input wire logic i_sense_int, // internal supply sense, pin
  input wire logic i_sense_gpio, // gpio 1 host sense, pin
  input wire logic i_rst_line_i, // host reset line level
  output logic o_rst_line_o, // host reset line drive level
  output logic o_rst_line_oe, // host reset line enable
  input wire logic i_pwr_line_i, // host power line level
  output logic o_pwr_line_o, // host power line drive level
  output logic o_pwr_line_oe, // host power line enable
  output logic o_display_off, // blank screen and backlight
  output logic [2:0] o_msg, // text shown, atx_msg_t
  output logic o_self_reset, // one-cycle device reboot
  output logic o_cmd_busy // commands being ignored
);
  localparam logic [7:0] HOLD_LONG = 8'(`ATX_HOLD_LONG_TK);
  localparam logic [7:0] PRESS = 8'(`ATX_PRESS_TK);
  localparam logic [7:0] RST_TK = 8'(`ATX_RST_PULSE_TK);
  localparam logic [7:0] EXT_TK = 8'(`ATX_EXT_MAX_TK);

  logic tick;
  logic [5:0] raw, s1_ff, s2_ff;
  logic key_conf, key_canc, sense, sense_d_ff;
  logic [7:0] conf_hold_ff, canc_hold_ff;
  atx_state_t state_ff, nxt_state;
  logic [7:0] pcnt_ff;
  logic key_rst_ff, from_wd;
  atx_cfg_t cfg_ff;
  logic [7:0] wd_cnt_ff;
  logic [4:0] wd_sub_ff;
  logic wd_fire_ff;
  logic rst_idle_ff, pwr_idle_ff, rst_level, pwr_level;
  logic wr_pend_ff;
  atx_reg_t wr_sel_ff;
  logic wr_ok, wr_cfg, wr_wd;
  logic [1:0] cfg_cnt;
  logic addr_ok;

  // counts must fit the 8-bit tick counters
  if (`ATX_EXT_MAX_TK > 255)
  begin : g_chk
    $error("tick counts exceed counter width");
  end

  // shared tick for every timed behaviour
  atx_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  // two-flop synchronisers for every pin input
  assign raw = {i_pwr_line_i, i_rst_line_i, i_sense_gpio,
                i_sense_int, i_key_cancel, i_key_confirm};
  for (genvar g = 0; g < 6; g++)
  begin : g_sync
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        s1_ff[g] <= 1'b0;
        s2_ff[g] <= 1'b0;
      end
      else
      begin
        s1_ff[g] <= raw[g];
        s2_ff[g] <= s1_ff[g];
      end
    end
  end

  assign key_conf = s2_ff[0];
  assign key_canc = s2_ff[1];
  // host sense source choice
  assign sense = cfg_ff.sense_sel ? s2_ff[2] : s2_ff[3];

  // hold time in ticks, saturating so a long hold fires once
  function automatic logic [7:0] hold_next(input logic [7:0] cnt,
                                           input logic key);
    logic [7:0] r;
    r = cnt;
    if (!key)
      r = 8'h00;
    else if (tick && cnt != 8'hFF)
      r = cnt + 8'h01;
    return r;
  endfunction

  // key hold counters, kept running even while host is off
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      conf_hold_ff <= 8'h00;
      canc_hold_ff <= 8'h00;
      sense_d_ff <= 1'b0;
    end
    else
    begin
      conf_hold_ff <= hold_next(conf_hold_ff, key_conf);
      canc_hold_ff <= hold_next(canc_hold_ff, key_canc);
      sense_d_ff <= sense;
    end
  end

  // sequencer next state; one pulse at a time, host sense edge first, then watchdog, then keys
  always_comb
  begin
    nxt_state = state_ff;
    from_wd = 1'b0;
    case (state_ff)
      ATX_IDLE:
      begin
        if (sense && !sense_d_ff)
          nxt_state = ATX_SELF;
        else if (wd_fire_ff)
        begin
          nxt_state = ATX_RST;
          from_wd = 1'b1;
        end
        else if (tick && key_conf && conf_hold_ff == HOLD_LONG - 8'h01
                 && sense && cfg_ff.mask[`ATX_B_KEY_RST])
          nxt_state = ATX_RST;
        else if (tick && key_conf && conf_hold_ff == PRESS - 8'h01
                 && !sense && cfg_ff.mask[`ATX_B_KEY_PON])
          nxt_state = ATX_PON;
        else if (tick && key_canc && canc_hold_ff == HOLD_LONG - 8'h01
                 && sense && cfg_ff.mask[`ATX_B_KEY_POFF])
          nxt_state = ATX_POFF;
      end
      ATX_RST:
      begin
        if (tick && pcnt_ff == RST_TK - 8'h01)
          nxt_state = key_rst_ff ? ATX_SELF : ATX_IDLE;
      end
      ATX_PON:
      begin
        if (tick && pcnt_ff == cfg_ff.pulse_len - 8'h01)
          nxt_state = ATX_SELF;
      end
      ATX_POFF:
      begin
        if (tick && pcnt_ff == cfg_ff.pulse_len - 8'h01)
          nxt_state = key_canc ? ATX_EXT : ATX_IDLE;
      end
      ATX_EXT:
      begin
        if (!key_canc)
          nxt_state = ATX_IDLE;
        else if (tick && pcnt_ff == EXT_TK - 8'h01)
          nxt_state = ATX_IDLE;
      end
      ATX_SELF:
        nxt_state = ATX_IDLE;
      default:
        nxt_state = ATX_IDLE;
    endcase
  end

  // state and pulse tick counter, restarted on each state change
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_ff <= ATX_IDLE;
      pcnt_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff)
        pcnt_ff <= 8'h00;
      else if (tick)
        pcnt_ff <= pcnt_ff + 8'h01;
    end
  end

  // key-started reset locks out commands until the device restarts
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      key_rst_ff <= 1'b0;
    else if (state_ff == ATX_IDLE && nxt_state == ATX_RST)
      key_rst_ff <= !from_wd;
    else if (state_ff == ATX_SELF)
      key_rst_ff <= 1'b0;
  end

  // idle level of each line, sampled only while released
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rst_idle_ff <= 1'b1;
      pwr_idle_ff <= 1'b1;
    end
    else
    begin
      if (!o_rst_line_oe)
        rst_idle_ff <= s2_ff[4];
      if (!o_pwr_line_oe)
        pwr_idle_ff <= s2_ff[5];
    end
  end

  // asserted level: opposite of idle when auto, else by invert bits
  assign rst_level = cfg_ff.mask[`ATX_B_AUTO_POL] ? !rst_idle_ff
                     : cfg_ff.mask[`ATX_B_RST_INV];
  assign pwr_level = cfg_ff.mask[`ATX_B_AUTO_POL] ? !pwr_idle_ff
                     : cfg_ff.mask[`ATX_B_PWR_INV];

  // line drivers: enabled only inside a pulse, high-z otherwise
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_rst_line_oe <= 1'b0;
      o_rst_line_o <= 1'b0;
      o_pwr_line_oe <= 1'b0;
      o_pwr_line_o <= 1'b0;
    end
    else
    begin
      o_rst_line_oe <= nxt_state == ATX_RST;
      o_rst_line_o <= rst_level;
      o_pwr_line_oe <= nxt_state == ATX_PON || nxt_state == ATX_POFF
                       || nxt_state == ATX_EXT;
      o_pwr_line_o <= pwr_level;
    end
  end

  // display text, blanking, reboot strobe and command lockout
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_msg <= ATX_MSG_BOOT;
      o_display_off <= 1'b0;
      o_self_reset <= 1'b0;
      o_cmd_busy <= 1'b0;
    end
    else
    begin
      case (nxt_state)
        ATX_RST:
          o_msg <= key_rst_ff || (state_ff == ATX_IDLE && !from_wd)
                   ? ATX_MSG_RESET : ATX_MSG_BOOT;
        ATX_PON: o_msg <= ATX_MSG_PWR_ON;
        ATX_POFF, ATX_EXT: o_msg <= ATX_MSG_PWR_OFF;
        default: o_msg <= ATX_MSG_BOOT;
      endcase
      o_display_off <= cfg_ff.mask[`ATX_B_BLANK] && !sense;
      o_self_reset <= nxt_state == ATX_SELF;
      o_cmd_busy <= key_rst_ff || (nxt_state == ATX_RST
                    && state_ff == ATX_IDLE && !from_wd);
    end
  end

  // register decode, shared by read and write paths
  function automatic atx_reg_t reg_sel(input logic [7:0] a);
    atx_reg_t r;
    r = ATX_R_NONE;
    if (a == `ATX_OFS_SWCFG)
      r = ATX_R_SWCFG;
    else if (a == `ATX_OFS_WDOG)
      r = ATX_R_WDOG;
    else if (a == `ATX_OFS_STATE)
      r = ATX_R_STATE;
    else if (a == `ATX_OFS_STAT0)
      r = ATX_R_STAT0;
    else if (a == `ATX_OFS_STAT1)
      r = ATX_R_STAT1;
    else if (a == `ATX_OFS_STAT2)
      r = ATX_R_STAT2;
    else if (a == `ATX_OFS_STAT3)
      r = ATX_R_STAT3;
    return r;
  endfunction

  // upper address bits must be zero to hit a register
  assign addr_ok = i_haddr[31:8] == 24'h000000;

  // address phase: zero wait states, so hreadyout stays high
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff <= ATX_R_NONE;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_ff <= 1'b0;
      if (i_hsel && i_hready && i_htrans[1])
      begin
        wr_pend_ff <= i_hwrite;
        wr_sel_ff <= addr_ok ? reg_sel(i_haddr[7:0]) : ATX_R_NONE;
        if (!i_hwrite)
        begin
          // unmapped addresses read as zero
          case (addr_ok ? reg_sel(i_haddr[7:0]) : ATX_R_NONE)
            ATX_R_SWCFG: o_hrdata <= {15'h0000, cfg_ff.sense_sel,
                                      cfg_ff.pulse_len, cfg_ff.mask};
            ATX_R_WDOG: o_hrdata <= {24'h000000, wd_cnt_ff};
            ATX_R_STATE: o_hrdata <= {21'h000000, o_msg, 1'b0,
                                      o_display_off, sense,
                                      o_cmd_busy, wd_fire_ff, state_ff};
            ATX_R_STAT1: o_hrdata <= {cfg_ff.mask, 24'h000000};
            ATX_R_STAT2: o_hrdata <= {7'h00, cfg_ff.sense_sel, 16'h0000,
                                      wd_cnt_ff};
            default: o_hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // data phase writes, dropped while commands are locked out
  assign wr_ok = wr_pend_ff && !o_cmd_busy && !key_rst_ff;
  assign wr_cfg = wr_ok && wr_sel_ff == ATX_R_SWCFG;
  assign wr_wd = wr_ok && wr_sel_ff == ATX_R_WDOG;
  assign cfg_cnt = i_hwdata[`ATX_F_COUNT_LSB+1:`ATX_F_COUNT_LSB];

  // switch configuration, payload count picks which bytes land
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cfg_ff.mask <= `ATX_RST_MASK;
      cfg_ff.pulse_len <= `ATX_RST_PULSE;
      cfg_ff.sense_sel <= `ATX_RST_SENSE;
    end
    else if (wr_cfg && cfg_cnt != 2'd0)
    begin
      cfg_ff.mask <= i_hwdata[7:0];
      if (cfg_cnt >= 2'd2)
        cfg_ff.pulse_len <= i_hwdata[`ATX_F_PULSE_LSB+7:`ATX_F_PULSE_LSB];
      if (cfg_cnt == 2'd3)
        cfg_ff.sense_sel <= i_hwdata[`ATX_F_SENSE_BIT];
    end
  end

  // watchdog: seconds left plus ticks within the second
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || state_ff == ATX_SELF)
    begin
      wd_cnt_ff <= 8'h00;
      wd_sub_ff <= 5'h00;
    end
    else if (wr_wd)
    begin
      wd_cnt_ff <= i_hwdata[7:0];
      wd_sub_ff <= 5'h00;
    end
    else if (tick && wd_cnt_ff != 8'h00)
    begin
      wd_sub_ff <= wd_sub_ff + 5'h01;
      if (wd_sub_ff == 5'h1F)
        wd_cnt_ff <= wd_cnt_ff - 8'h01; // reaching zero disarms
    end
  end

  // expiry request held until the sequencer takes it; set wins
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || state_ff == ATX_SELF)
      wd_fire_ff <= 1'b0;
    else if (tick && wd_cnt_ff == 8'h01 && wd_sub_ff == 5'h1F && !wr_wd)
      wd_fire_ff <= 1'b1;
    else if (from_wd)
      wd_fire_ff <= 1'b0;
  end
endmodule // atx_ctrl

// File: rtl/atx_defs.svh
// constants for the atx switch emulation and host watchdog block
`ifndef ATX_DEFS_SVH
`define ATX_DEFS_SVH
// clock and common tick
`define ATX_CLK_MHZ 50
`define ATX_TICK_US 31250
`define ATX_TICK_CYC (`ATX_CLK_MHZ * `ATX_TICK_US)
`define ATX_TICKS_PER_S 32
// key and pulse timing, times in their own unit
`define ATX_HOLD_LONG_S 4
`define ATX_PRESS_MS 250
`define ATX_RST_PULSE_S 1
`define ATX_EXT_MAX_S 5
`define ATX_HOLD_LONG_TK (`ATX_HOLD_LONG_S * `ATX_TICKS_PER_S)
`define ATX_PRESS_TK ((`ATX_PRESS_MS * `ATX_TICKS_PER_S + 999) / 1000)
`define ATX_RST_PULSE_TK (`ATX_RST_PULSE_S * `ATX_TICKS_PER_S)
`define ATX_EXT_MAX_TK (`ATX_EXT_MAX_S * `ATX_TICKS_PER_S)
// register byte offsets
`define ATX_OFS_SWCFG 8'h00
`define ATX_OFS_WDOG 8'h04
`define ATX_OFS_STATE 8'h08
`define ATX_OFS_STAT0 8'h10
`define ATX_OFS_STAT1 8'h14
`define ATX_OFS_STAT2 8'h18
`define ATX_OFS_STAT3 8'h1C
// function mask bit positions
`define ATX_B_AUTO_POL 0
`define ATX_B_RST_INV 1
`define ATX_B_PWR_INV 2
`define ATX_B_BLANK 4
`define ATX_B_KEY_RST 5
`define ATX_B_KEY_PON 6
`define ATX_B_KEY_POFF 7
// switch config word fields
`define ATX_F_PULSE_LSB 8
`define ATX_F_SENSE_BIT 16
`define ATX_F_COUNT_LSB 24
// reset values
`define ATX_RST_MASK 8'h00
`define ATX_RST_PULSE 8'h20
`define ATX_RST_SENSE 1'b1
`endif

// File: rtl/atx_pkg.sv
// types for the atx switch emulation and host watchdog block
package atx_pkg;
  // sequencer states, gray along the idle-rst-self and idle-pon-self paths
  typedef enum logic [2:0] {
    ATX_IDLE = 3'h0,
    ATX_RST = 3'h1,
    ATX_SELF = 3'h3,
    ATX_PON = 3'h2,
    ATX_POFF = 3'h6,
    ATX_EXT = 3'h7
  } atx_state_t;
  // text the display is asked to show
  typedef enum logic [2:0] {
    ATX_MSG_BOOT = 3'h0,
    ATX_MSG_RESET = 3'h1,
    ATX_MSG_PWR_ON = 3'h2,
    ATX_MSG_PWR_OFF = 3'h3
  } atx_msg_t;
  // register selector
  typedef enum logic [2:0] {
    ATX_R_NONE, ATX_R_SWCFG, ATX_R_WDOG, ATX_R_STATE,
    ATX_R_STAT0, ATX_R_STAT1, ATX_R_STAT2, ATX_R_STAT3
  } atx_reg_t;
  // switch configuration set by the host
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] pulse_len;
    logic sense_sel;
  } atx_cfg_t;
endpackage

// File: rtl/atx_tick.sv
// free-running divider making the common 1/32 second tick
`timescale 1ns/10ps
module atx_tick #(
  parameter int TICK_CYC = 1562500
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // sync reset, active high
  output logic o_tick // one-cycle tick pulse
);
  localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);
  logic [CW-1:0] cnt_ff;
  logic tick_ff;

  // refuse a divide ratio below one cycle
  if (TICK_CYC < 1)
  begin : g_chk
    $error("TICK_CYC must be at least 1");
  end

  // divider counter and registered tick
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (cnt_ff == LAST)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  assign o_tick = tick_ff;
endmodule // atx_tick

// File: verif/atx_ctrl_sva.sv
// port assertions for the atx switch and watchdog block
`timescale 1ns/10ps
module atx_ctrl_sva
  import atx_pkg::*;
#(
  parameter int TICK_CYC = 4
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // sync reset
  input wire logic o_hreadyout, // bus ready
  input wire logic o_hresp, // bus response
  input wire logic o_rst_line_o, // reset drive level
  input wire logic o_rst_line_oe, // reset enable
  input wire logic o_pwr_line_o, // power drive level
  input wire logic o_pwr_line_oe, // power enable
  input wire logic [2:0] o_msg, // text shown
  input wire logic o_self_reset, // device reboot
  input wire logic o_cmd_busy // commands ignored
);
  logic [15:0] rst_cnt_ff;
  logic [15:0] pwr_cnt_ff;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // high-time counters, kept after the fall so the length can be judged
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst) rst_cnt_ff <= 16'h0;
    else if (o_rst_line_oe) rst_cnt_ff <= $past(o_rst_line_oe) ? rst_cnt_ff + 16'h1 : 16'h1;
    if (i_rst) pwr_cnt_ff <= 16'h0;
    else if (o_pwr_line_oe) pwr_cnt_ff <= $past(o_pwr_line_oe) ? pwr_cnt_ff + 16'h1 : 16'h1;
  end
  sequence s_pon_end;
    $fell(o_pwr_line_oe) && $past(o_msg) == ATX_MSG_PWR_ON;
  endsequence
  property p_pon_self; s_pon_end |-> ##[0:4] o_self_reset; endproperty
  a_pon_self: assert property (p_pon_self) else $error("no reboot after power-up");
  property p_rst_len;
    $fell(o_rst_line_oe) |-> rst_cnt_ff >= 31 * TICK_CYC && rst_cnt_ff <= 33 * TICK_CYC;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
  property p_pwr_max; pwr_cnt_ff <= 418 * TICK_CYC; endproperty
  a_pwr_max: assert property (p_pwr_max) else $error("power pulse too long");
  property p_msg_pwr;
    o_pwr_line_oe && $past(o_pwr_line_oe) |-> o_msg inside {ATX_MSG_PWR_ON, ATX_MSG_PWR_OFF};
  endproperty
  a_msg_pwr: assert property (p_msg_pwr) else $error("power text");
  property p_msg_rst; o_msg == ATX_MSG_RESET && $past(o_msg) == ATX_MSG_RESET |-> o_cmd_busy;
  endproperty
  a_msg_rst: assert property (p_msg_rst) else $error("commands taken in reset");
  property p_rst_lvl; o_rst_line_oe && $past(o_rst_line_oe) |-> $stable(o_rst_line_o); endproperty
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset level moved");
  property p_pwr_lvl; o_pwr_line_oe && $past(o_pwr_line_oe) |-> $stable(o_pwr_line_o); endproperty
  a_pwr_lvl: assert property (p_pwr_lvl) else $error("power level moved");
  property p_self_one; o_self_reset |=> !o_self_reset; endproperty
  a_self_one: assert property (p_self_one) else $error("reboot pulse long");
  property p_okay; o_hreadyout && !o_hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule // atx_ctrl_sva

// File: verif/atx_host_model.sv
// host-side model of the atx power and reset switch wiring
`timescale 1ns/10ps
module atx_host_model (
  input wire logic i_sys_clk, // clock
  input wire logic i_load, // force host state, clear counts
  input wire logic i_on, // host state to load
  input wire logic i_rst_o, // reset drive level
  input wire logic i_rst_oe, // reset enable
  input wire logic i_pwr_o, // power drive level
  input wire logic i_pwr_oe, // power enable
  output logic o_rst_lvl, // reset wire level
  output logic o_pwr_lvl, // power wire level
  output logic o_host_on, // host supply sense
  output logic [7:0] o_rst_cnt // reset pulses seen
);
  logic pwr_q;
  logic rst_q;
  // pull-ups take a released line high
  assign o_rst_lvl = i_rst_oe ? i_rst_o : 1'b1;
  assign o_pwr_lvl = i_pwr_oe ? i_pwr_o : 1'b1;
  // pins only read here, never reused; a power press toggles the supply
  always @(posedge i_sys_clk)
  begin
    pwr_q <= i_pwr_oe;
    rst_q <= i_rst_oe;
    if (i_load) o_host_on <= i_on;
    else if (pwr_q && !i_pwr_oe) o_host_on <= !o_host_on;
    if (i_load) o_rst_cnt <= 8'h00;
    else if (i_rst_oe && !rst_q) o_rst_cnt <= o_rst_cnt + 8'h01;
  end
endmodule // atx_host_model

// File: verif/atx_ctrl_bench.sv
// self-checking bench for the atx switch and watchdog block
`timescale 1ns/10ps
module atx_ctrl_bench;
  import atx_pkg::*;
  localparam int TC = 4;
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, kc = 1'b0, kx = 1'b0, sg = 1'b0;
  logic ld = 1'b1, on = 1'b0, hrdy, hresp, rlo, rloe, plo, ploe, doff, sr, busy;
  logic rlvl, plvl, host_on, l0, b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [2:0] msg, m0;
  logic [7:0] rcnt, rc0;
  int fail_count = 0, tests_run = 0, sr_n = 0, w, len;
  always #10 clk = ~clk;
  atx_ctrl #(.TICK_CYC(TC)) i_dut (.i_sys_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp), .i_key_confirm(kc),
    .i_key_cancel(kx), .i_sense_int(host_on), .i_sense_gpio(sg), .i_rst_line_i(rlvl),
    .o_rst_line_o(rlo), .o_rst_line_oe(rloe), .i_pwr_line_i(plvl), .o_pwr_line_o(plo),
    .o_pwr_line_oe(ploe), .o_display_off(doff), .o_msg(msg), .o_self_reset(sr),
    .o_cmd_busy(busy));
  atx_host_model i_host (.i_sys_clk(clk), .i_load(ld), .i_on(on), .i_rst_o(rlo),
    .i_rst_oe(rloe), .i_pwr_o(plo), .i_pwr_oe(ploe), .o_rst_lvl(rlvl), .o_pwr_lvl(plvl),
    .o_host_on(host_on), .o_rst_cnt(rcnt));
  // reboot pulses are counted so a scenario can ask whether one happened
  always @(posedge clk)
    if (sr === 1'b1) sr_n++;
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    $display("ERROR %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  // one single word transfer; the master never assumes the slave's latency
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 40);
    r = hrdata;
    if (n >= 40) tmo();
  endtask
  // waits for a line to be driven, notes its first state and its length
  task automatic pulse(input logic p, input int lim);
    w = 0;
    len = 0;
    while ((p ? ploe : rloe) !== 1'b1)
    begin
      @(posedge clk);
      if (++w > lim) tmo();
    end
    m0 = msg;
    l0 = p ? plo : rlo;
    b0 = busy;
    while ((p ? ploe : rloe) === 1'b1 && len < 3000)
    begin
      @(posedge clk);
      len++;
    end
  endtask
  task automatic t_reset();
    bus(0, 32'h00, 0); chk(r, 32'h0001_2000);
    bus(0, 32'h04, 0); chk(r, 32'h0);
    bus(0, 32'h10, 0); chk(r, 32'h0);
    bus(0, 32'h1C, 0); chk(r, 32'h0);
    bus(0, 32'h40, 0); chk(r, 32'h0);
  endtask
  task automatic t_cfg();
    bus(1, 32'h00, 32'h0301_08F0);
    bus(0, 32'h00, 0); chk(r, 32'h0001_08F0);
    bus(0, 32'h14, 0); chk(r, 32'hF000_0000);
    bus(0, 32'h18, 0); chk(r, 32'h0100_0000);
    bus(1, 32'h00, 32'h0100_FF40);
    bus(1, 32'h00, 32'h0000_0000);
    bus(0, 32'h00, 0); chk(r, 32'h0001_0840);
  endtask
  task automatic t_pwr_on();
    sr_n = 0;
    kc <= 1'b1;
    pulse(1, 200);
    kc <= 1'b0;
    chk(m0, ATX_MSG_PWR_ON);
    chk(l0, 1'b0);
    ok(len >= 7 * TC && len <= 9 * TC);
    ok(w >= 7 * TC);
    repeat (20) @(posedge clk);
    ok(sr_n >= 1 && host_on === 1'b1);
  endtask
  task automatic t_restart();
    bus(1, 32'h00, 32'h0301_0823); // auto polarity wins over invert
    sr_n = 0;
    kc <= 1'b1;
    pulse(0, 700);
    kc <= 1'b0;
    chk(m0, ATX_MSG_RESET);
    chk(l0, 1'b0);
    chk(b0, 1'b1);
    ok(len >= 31 * TC && len <= 33 * TC && w >= 127 * TC);
    repeat (20) @(posedge clk);
    ok(sr_n >= 1);
  endtask
  task automatic t_pwr_off();
    bus(1, 32'h00, 32'h0301_0884);
    kx <= 1'b1;
    pulse(1, 700);
    kx <= 1'b0;
    chk(m0, ATX_MSG_PWR_OFF);
    chk(l0, 1'b1);
    ok(w >= 127 * TC);
    ok(len >= 167 * TC && len <= 169 * TC);
  endtask
  task automatic t_wdog();
    bus(1, 32'h04, 32'h0);
    bus(0, 32'h04, 0); chk(r, 32'h0);
    bus(1, 32'h04, 32'h2);
    bus(0, 32'h04, 0); chk(r, 32'h2);
    repeat (3)
    begin
      repeat (100) @(posedge clk);
      bus(1, 32'h04, 32'h1);
    end
    ok(rloe === 1'b0);
    sr_n = 0;
    pulse(0, 300);
    ok(w >= 28 * TC && w <= 34 * TC && len >= 31 * TC && len <= 33 * TC);
    bus(0, 32'h04, 0); chk(r, 32'h0);
    rc0 = rcnt;
    bus(1, 32'h04, 32'h1);
    bus(1, 32'h04, 32'h0);
    repeat (300) @(posedge clk);
    ok(rcnt === rc0 && sr_n == 0);
  endtask
  task automatic t_blank();
    bus(1, 32'h00, 32'h0301_0810);
    repeat (6) @(posedge clk);
    chk(doff, 1'b1);
    bus(1, 32'h00, 32'h0300_0810);
    ld <= 1'b1;
    on <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (6) @(posedge clk);
    chk(doff, 1'b1);
    sr_n = 0;
    sg <= 1'b1;
    repeat (10) @(posedge clk);
    chk(doff, 1'b0);
    ok(sr_n >= 1);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ld <= 1'b0;
    t_reset();
    t_cfg();
    t_pwr_on();
    t_restart();
    t_pwr_off();
    t_wdog();
    t_blank();
    end_sim();
  end
  // whole-run guard against a hang outside the bounded waits
  initial
  begin
    #400000;
    tmo();
  end
endmodule // atx_ctrl_bench
bind atx_ctrl atx_ctrl_sva #(.TICK_CYC(TICK_CYC)) u_sva (.i_sys_clk, .i_rst, .o_hreadyout,
  .o_hresp, .o_rst_line_o, .o_rst_line_oe, .o_pwr_line_o, .o_pwr_line_oe, .o_msg,
  .o_self_reset, .o_cmd_busy);
